// *** verilog/pefb_pkg.sv ***
`default_nettype none
package pefb_pkg;
	localparam int PEFB_ADDR_W = 12;
	localparam int PEFB_DATA_W = 8;
	localparam int PEFB_NUM_CCP = 4;
	localparam int PEFB_NUM_GATE = 3;

	localparam logic [11:0] PEFB_OFF_GATE = 12'h711;
	localparam logic [11:0] PEFB_OFF_CCP = 12'h712;
	localparam logic [11:0] PEFB_OFF_INT_STAT = 12'h713;
	localparam logic [11:0] PEFB_OFF_INT_MASK = 12'h714;

	localparam int PEFB_BIT_LC1 = 4;
	localparam int PEFB_BIT_TMR5G = 2;
	localparam int PEFB_BIT_TMR3G = 1;
	localparam int PEFB_BIT_TMR1G = 0;
	localparam int PEFB_IST_GATE = 0;
	localparam int PEFB_IST_CCP = 1;

	localparam logic [7:0] PEFB_GATE_IMPL = 8'h17;
	localparam logic [7:0] PEFB_CCP_IMPL = 8'h0F;
	localparam logic [7:0] PEFB_INT_IMPL = 8'h03;
	localparam logic [7:0] PEFB_RST_FLAGS = 8'h00;
	localparam logic [7:0] PEFB_RST_MASK = 8'h00;

	typedef enum logic [1:0] {
		PEFB_MODE_OFF,
		PEFB_MODE_CAPTURE,
		PEFB_MODE_COMPARE,
		PEFB_MODE_PWM
	} pefb_ccp_mode_e;

	typedef struct packed {
		pefb_ccp_mode_e mode;
		logic capture;
		logic match;
		logic pwm_out;
	} pefb_ccp_s;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pefb_bus_s;
endpackage
`default_nettype wire

// *** verilog/pefb_flag_bank.sv ***
// Summary of operation
// [R1] The logic cell 1 flag at bit 4 sets on that cell's output interrupt event and stays until cleared.
// [R2] The timer 5 gate flag at bit 2 sets when that gate goes inactive and stays clear otherwise; the code also sets it on a bus write of 1 to bit 2.
// [R3] The timer 3 gate flag at bit 1 sets when that gate goes inactive.
// [R4] The timer 1 gate flag at bit 0 sets when that gate goes inactive.
// [R5] Flags set on their event regardless of any enable or mask.
// [R6] Software clears a flag before enabling its interrupt source.
// [R7] In capture mode a capture sets that module's flag in bits 3 to 0.
// [R8] In compare mode a compare match sets that module's flag.
// [R9] In PWM mode an output trailing edge sets that module's flag.
// [R10] The capture/compare flag register is at 0x712, upper bits read zero, flags reset to zero.
// [R11] The logic cell and gate flag register is at 0x711, read/write, reset to zero.
// [R12] Writing zero clears a flag, but a coincident hardware set wins.
`default_nettype none
module pefb_flag_bank
	import pefb_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire pefb_bus_s bus,
	output logic [7:0] rdata,
	input wire logic logic_cell1_output,
	input wire logic [2:0] timer_gate_active,
	input wire pefb_ccp_s [3:0] ccp_in,
	output logic [7:0] logic_cell_and_gate_flags,
	output logic [7:0] ccp_event_flags,
	output logic irq
);

	function automatic logic fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [2:0] gate_prev;
	logic [3:0] pwm_prev;
	logic [7:0] int_stat;
	logic [7:0] int_mask;
	logic [7:0] next_gate;
	logic [7:0] next_ccp;
	logic [7:0] next_stat;
	logic [7:0] next_rdata;
	logic [7:0] gate_set;
	logic [7:0] ccp_set;
	logic [7:0] stat_set;

	wire wr_gate = bus.wr & hit(bus.addr, PEFB_OFF_GATE);
	wire wr_ccp = bus.wr & hit(bus.addr, PEFB_OFF_CCP);
	wire wr_stat = bus.wr & hit(bus.addr, PEFB_OFF_INT_STAT);
	wire wr_mask = bus.wr & hit(bus.addr, PEFB_OFF_INT_MASK);

	// Gate inactive is the falling edge of the gate-active level
	wire tmr1_done = fell(gate_prev[0], timer_gate_active[0]);
	wire tmr3_done = fell(gate_prev[1], timer_gate_active[1]);
	wire tmr5_done = fell(gate_prev[2], timer_gate_active[2]);

	always_comb begin
		gate_set = 8'h00;
		gate_set[PEFB_BIT_LC1] = logic_cell1_output; // [R1]
		gate_set[PEFB_BIT_TMR5G] = tmr5_done; // [R2]
		gate_set[PEFB_BIT_TMR3G] = tmr3_done; // [R3]
		gate_set[PEFB_BIT_TMR1G] = tmr1_done; // [R4]
	end

	// Mode picks which event counts; other events are ignored
	always_comb begin
		ccp_set = 8'h00;
		for (int i = 0; i < PEFB_NUM_CCP; i++) begin
			case (ccp_in[i].mode)
				PEFB_MODE_CAPTURE: ccp_set[i] = ccp_in[i].capture; // [R7]
				PEFB_MODE_COMPARE: ccp_set[i] = ccp_in[i].match; // [R8]
				PEFB_MODE_PWM: ccp_set[i] = fell(pwm_prev[i], ccp_in[i].pwm_out); // [R9]
				default: ccp_set[i] = 1'b0;
			endcase
		end
	end

	// Set ORed after the write so a coincident event is never lost
	assign next_gate = ((wr_gate ? bus.wdata : logic_cell_and_gate_flags) | gate_set)
		& PEFB_GATE_IMPL; // [R11] [R12] [R5]
	assign next_ccp = ((wr_ccp ? bus.wdata : ccp_event_flags) | ccp_set) & PEFB_CCP_IMPL; // [R10] [R12] [R5]

	always_comb begin
		stat_set = 8'h00;
		stat_set[PEFB_IST_GATE] = |gate_set;
		stat_set[PEFB_IST_CCP] = |ccp_set;
	end
	assign next_stat = ((int_stat & ~(wr_stat ? bus.wdata : 8'h00)) | stat_set) & PEFB_INT_IMPL;

	always_comb begin
		next_rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				PEFB_OFF_GATE: next_rdata = logic_cell_and_gate_flags;
				PEFB_OFF_CCP: next_rdata = ccp_event_flags; // [R10]
				PEFB_OFF_INT_STAT: next_rdata = int_stat;
				PEFB_OFF_INT_MASK: next_rdata = int_mask;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (srst) begin
			logic_cell_and_gate_flags <= PEFB_RST_FLAGS; // [R11]
			ccp_event_flags <= PEFB_RST_FLAGS; // [R10]
			int_stat <= PEFB_RST_FLAGS;
			int_mask <= PEFB_RST_MASK;
			gate_prev <= 3'h0;
			pwm_prev <= 4'h0;
			rdata <= 8'h00;
		end else begin
			logic_cell_and_gate_flags <= next_gate;
			ccp_event_flags <= next_ccp;
			int_stat <= next_stat;
			int_mask <= wr_mask ? (bus.wdata & PEFB_INT_IMPL) : int_mask;
			gate_prev <= timer_gate_active;
			for (int i = 0; i < PEFB_NUM_CCP; i++) begin
				pwm_prev[i] <= ccp_in[i].pwm_out;
			end
			rdata <= next_rdata;
		end
	end

	// Level output; stale flags fire at once if unmasked, software clears first
	assign irq = |(int_stat & int_mask); // [R6]

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	property p_lc1_set;
		logic_cell1_output |=> logic_cell_and_gate_flags[4] [*2] or
			(logic_cell_and_gate_flags[4] ##1 1'b1);
	endproperty
	a_lc1_set: assert property (p_lc1_set) else $error("lc1 flag not set"); // [R1]

	property p_tmr5_set;
		(!$past(srst) && $fell(timer_gate_active[2])) |=> logic_cell_and_gate_flags[2];
	endproperty
	a_tmr5_set: assert property (p_tmr5_set) else $error("tmr5 gate flag not set"); // [R2]

	property p_tmr5_hold_clear;
		(!logic_cell_and_gate_flags[2] && !bus.wr && !(gate_prev[2] && !timer_gate_active[2]))
			|=> !logic_cell_and_gate_flags[2];
	endproperty
	a_tmr5_hold_clear: assert property (p_tmr5_hold_clear) else $error("tmr5 flag set spuriously"); // [R2]

	property p_tmr3_set;
		(!$past(srst) && $fell(timer_gate_active[1])) |=> logic_cell_and_gate_flags[1];
	endproperty
	a_tmr3_set: assert property (p_tmr3_set) else $error("tmr3 gate flag not set"); // [R3]

	property p_tmr1_set;
		(!$past(srst) && $fell(timer_gate_active[0]) && int_mask == 8'h00 && !wr_mask)
			|=> logic_cell_and_gate_flags[0] && !irq;
	endproperty
	a_tmr1_set: assert property (p_tmr1_set) else $error("tmr1 flag not set without enable"); // [R4] [R5]

	property p_capture;
		(ccp_in[0].mode == PEFB_MODE_CAPTURE && ccp_in[0].capture) |=> ccp_event_flags[0];
	endproperty
	a_capture: assert property (p_capture) else $error("capture flag not set"); // [R7]

	property p_compare;
		(ccp_in[1].mode == PEFB_MODE_COMPARE && ccp_in[1].match) |=> ccp_event_flags[1];
	endproperty
	a_compare: assert property (p_compare) else $error("compare flag not set"); // [R8]

	property p_pwm_edge;
		(!$past(srst) && ccp_in[3].mode == PEFB_MODE_PWM && $fell(ccp_in[3].pwm_out))
			|=> ccp_event_flags[3];
	endproperty
	a_pwm_edge: assert property (p_pwm_edge) else $error("pwm trailing flag not set"); // [R9]

	property p_ccp_read;
		(bus.rd && bus.addr == PEFB_OFF_CCP) |=> rdata == {4'h0, $past(ccp_event_flags[3:0])};
	endproperty
	a_ccp_read: assert property (p_ccp_read) else $error("ccp read wrong"); // [R10]

	property p_reset_zero;
		// First edge of the run sees unknown flags, so only the release edge is judged
		($past(srst) && !srst) |-> logic_cell_and_gate_flags == 8'h00 && ccp_event_flags == 8'h00;
	endproperty
	a_reset_zero: assert property (@(posedge core_clk) disable iff (1'b0) p_reset_zero)
		else $error("flags not zero after reset"); // [R11]

	property p_clear_vs_set;
		(wr_gate && !bus.wdata[4]) |=> logic_cell_and_gate_flags[4] == $past(logic_cell1_output);
	endproperty
	a_clear_vs_set: assert property (p_clear_vs_set) else $error("clear or set priority wrong"); // [R12]

	property p_lc1_hold_clear;
		(!logic_cell_and_gate_flags[4] && !bus.wr && !logic_cell1_output)
			|=> !logic_cell_and_gate_flags[4];
	endproperty
	a_lc1_hold_clear: assert property (p_lc1_hold_clear) else $error("lc1 flag set spuriously"); // [R1]

	property p_tmr3_hold_clear;
		(!logic_cell_and_gate_flags[1] && !bus.wr && !(gate_prev[1] && !timer_gate_active[1]))
			|=> !logic_cell_and_gate_flags[1];
	endproperty
	a_tmr3_hold_clear: assert property (p_tmr3_hold_clear) else $error("tmr3 flag set spuriously"); // [R3]

	property p_tmr1_hold_clear;
		(!logic_cell_and_gate_flags[0] && !bus.wr && !(gate_prev[0] && !timer_gate_active[0]))
			|=> !logic_cell_and_gate_flags[0];
	endproperty
	a_tmr1_hold_clear: assert property (p_tmr1_hold_clear) else $error("tmr1 flag set spuriously"); // [R4]

	property p_gate_sticky;
		!wr_gate
			|=> (logic_cell_and_gate_flags & $past(logic_cell_and_gate_flags)) == $past(logic_cell_and_gate_flags);
	endproperty
	a_gate_sticky: assert property (p_gate_sticky) else $error("gate flag lost without write"); // [R11]

	property p_ccp_sticky;
		!wr_ccp
			|=> (ccp_event_flags & $past(ccp_event_flags)) == $past(ccp_event_flags);
	endproperty
	a_ccp_sticky: assert property (p_ccp_sticky) else $error("ccp flag lost without write"); // [R10]

	property p_gate_unimpl;
		(logic_cell_and_gate_flags & ~PEFB_GATE_IMPL) == 8'h00;
	endproperty
	a_gate_unimpl: assert property (p_gate_unimpl) else $error("gate register spare bit set"); // [R11]

	property p_ccp_upper_zero;
		ccp_event_flags[7:4] == 4'h0;
	endproperty
	a_ccp_upper_zero: assert property (p_ccp_upper_zero) else $error("ccp register upper bit set"); // [R10]

	property p_capture_m2;
		(ccp_in[2].mode == PEFB_MODE_CAPTURE && ccp_in[2].capture)
			|=> ccp_event_flags[2];
	endproperty
	a_capture_m2: assert property (p_capture_m2) else $error("module 2 capture flag not set"); // [R7]

	property p_capture_m3;
		(ccp_in[3].mode == PEFB_MODE_CAPTURE && ccp_in[3].capture)
			|=> ccp_event_flags[3];
	endproperty
	a_capture_m3: assert property (p_capture_m3) else $error("module 3 capture flag not set"); // [R7]

	property p_compare_m0;
		(ccp_in[0].mode == PEFB_MODE_COMPARE && ccp_in[0].match)
			|=> ccp_event_flags[0];
	endproperty
	a_compare_m0: assert property (p_compare_m0) else $error("module 0 compare flag not set"); // [R8]

	property p_pwm_m2;
		(!$past(srst) && ccp_in[2].mode == PEFB_MODE_PWM && $fell(ccp_in[2].pwm_out))
			|=> ccp_event_flags[2];
	endproperty
	a_pwm_m2: assert property (p_pwm_m2) else $error("module 2 trailing flag not set"); // [R9]

	// Wrong-kind events must not leak into the flag
	property p_capture_ignores;
		(ccp_in[0].mode == PEFB_MODE_CAPTURE && !ccp_in[0].capture && !wr_ccp && !ccp_event_flags[0])
			|=> !ccp_event_flags[0];
	endproperty
	a_capture_ignores: assert property (p_capture_ignores) else $error("capture flag set by other event"); // [R7]

	property p_compare_ignores;
		(ccp_in[1].mode == PEFB_MODE_COMPARE && !ccp_in[1].match && !wr_ccp && !ccp_event_flags[1])
			|=> !ccp_event_flags[1];
	endproperty
	a_compare_ignores: assert property (p_compare_ignores) else $error("compare flag set by other event"); // [R8]

	property p_mode_off;
		(ccp_in[0].mode == PEFB_MODE_OFF && !wr_ccp && !ccp_event_flags[0])
			|=> !ccp_event_flags[0];
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("flag set while module off"); // [R7]

	property p_gate_write_clear;
		(wr_gate && bus.wdata == 8'h00 && gate_set == 8'h00)
			|=> logic_cell_and_gate_flags == 8'h00;
	endproperty
	a_gate_write_clear: assert property (p_gate_write_clear) else $error("gate flags not cleared"); // [R12]

	property p_ccp_write_clear;
		(wr_ccp && bus.wdata == 8'h00 && ccp_set == 8'h00)
			|=> ccp_event_flags == 8'h00;
	endproperty
	a_ccp_write_clear: assert property (p_ccp_write_clear) else $error("ccp flags not cleared"); // [R12]

	property p_ccp_clear_vs_set;
		(wr_ccp && ccp_set[0])
			|=> ccp_event_flags[0];
	endproperty
	a_ccp_clear_vs_set: assert property (p_ccp_clear_vs_set) else $error("ccp event lost to write"); // [R12]

	property p_poll_no_mask;
		(ccp_in[1].mode == PEFB_MODE_COMPARE && ccp_in[1].match && int_mask == 8'h00 && !wr_mask)
			|=> ccp_event_flags[1] && !irq;
	endproperty
	a_poll_no_mask: assert property (p_poll_no_mask) else $error("masked event raised irq"); // [R5]

	property p_stat_gate_set;
		(|gate_set)
			|=> int_stat[PEFB_IST_GATE];
	endproperty
	a_stat_gate_set: assert property (p_stat_gate_set) else $error("gate event missing in status"); // [R5]

	property p_mask_write;
		wr_mask
			|=> int_mask == ($past(bus.wdata) & PEFB_INT_IMPL);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write not stored"); // [R6]

	property p_gate_read;
		(bus.rd && bus.addr == PEFB_OFF_GATE)
			|=> rdata == $past(logic_cell_and_gate_flags);
	endproperty
	a_gate_read: assert property (p_gate_read) else $error("gate read wrong"); // [R11]

	property p_rdata_idle;
		!bus.rd
			|=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // [R11]

	c_irq: cover property (logic_cell1_output && int_mask[0] ##1 irq);
	c_gate_race: cover property (wr_gate && !bus.wdata[4] && logic_cell1_output);
	c_pwm_m2: cover property (ccp_in[2].mode == PEFB_MODE_PWM && ccp_set[2]);
	c_clear_race: cover property (wr_ccp && bus.wdata[0] == 1'b0 && ccp_set[0]);
	c_pwm: cover property (ccp_in[2].mode == PEFB_MODE_PWM ##1 ccp_event_flags[2]);

endmodule
`default_nettype wire

// *** bench/pefb_periph.sv ***
`default_nettype none
module pefb_periph
	import pefb_pkg::*;
(
	input wire logic core_clk,
	output logic lc_out,
	output logic [2:0] gate,
	output pefb_ccp_s [3:0] ccp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		lc_out = 1'b0;
		gate = 3'h0;
		ccp = '0;
	end
	////////////////////////////////////////////////////////////////
	// Ends one edge after the event lands, so caller waits #1
	task automatic lc_pulse;
		@(posedge core_clk) lc_out <= 1'b1;
		@(posedge core_clk) lc_out <= 1'b0;
		@(posedge core_clk);
	endtask
	// Gate goes active then inactive; only the fall counts
	task automatic gate_fall(int i);
		@(posedge core_clk) gate[i] <= 1'b1;
		@(posedge core_clk) gate[i] <= 1'b0;
		@(posedge core_clk);
	endtask
	// Kind bits are capture, match, pwm_out; pwm fall is the trailing edge
	task automatic pulse(int m, pefb_ccp_mode_e md, logic [2:0] k);
		@(posedge core_clk) ccp[m] <= {md, k};
		@(posedge core_clk) ccp[m] <= {md, 3'h0};
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	import pefb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	pefb_bus_s bus = '0;
	logic [7:0] rdata, lgf, ccf;
	logic irq, lc;
	logic [2:0] gate;
	pefb_ccp_s [3:0] ccp;
	int n_mismatch = 0;
	int n_compared = 0;
	always #2.5 core_clk = ~core_clk;
	pefb_flag_bank u_pefb_flag_bank(.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
		.logic_cell1_output(lc), .timer_gate_active(gate), .ccp_in(ccp),
		.logic_cell_and_gate_flags(lgf), .ccp_event_flags(ccf), .irq(irq));
	pefb_periph u_pefb_periph(.core_clk(core_clk), .lc_out(lc), .gate(gate), .ccp(ccp));
	////////////////////////////////////////////////////////////////
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk) bus.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [11:0] a, logic [7:0] e);
		@(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) bus.rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// 0x715 is unmapped and must read zero too
	task automatic t_reset;
		for (int a = 'h711; a <= 'h715; a++) rd(12'(a), 8'h00);
		$display("reset test done");
	endtask
	task automatic t_gate;
		for (int i = 0; i < 3; i++) u_pefb_periph.gate_fall(i);
		u_pefb_periph.lc_pulse;
		#1 `CHK(lgf, 8'h17)
		`CHK(irq, 1'b0)
		rd(12'h713, 8'h01);
		wr(12'h714, 8'h01);
		#1 `CHK(irq, 1'b1)
		wr(12'h711, 8'h00);
		rd(12'h711, 8'h00);
		wr(12'h713, 8'h01);
		#1 `CHK(irq, 1'b0)
		$display("gate test done");
	endtask
	task automatic t_ccp;
		for (int m = 0; m < 4; m++) u_pefb_periph.pulse(m, PEFB_MODE_OFF, 3'h7);
		u_pefb_periph.pulse(0, PEFB_MODE_CAPTURE, 3'h3);
		u_pefb_periph.pulse(1, PEFB_MODE_COMPARE, 3'h5);
		#1 `CHK(ccf, 8'h00)
		for (int m = 0; m < 4; m++) u_pefb_periph.pulse(m, pefb_ccp_mode_e'(m % 3 + 1), 3'h4 >> (m % 3));
		#1 `CHK(ccf, 8'h0F)
		rd(12'h713, 8'h02);
		wr(12'h714, 8'h02);
		#1 `CHK(irq, 1'b1)
		wr(12'h713, 8'h02);
		#1 `CHK(irq, 1'b0)
		wr(12'h712, 8'h00);
		rd(12'h712, 8'h00);
		wr(12'h712, 8'hFF);
		rd(12'h712, 8'h0F);
		$display("ccp test done");
	endtask
	// Clearing write and event meet at one edge; the event must survive
	task automatic t_race;
		fork
			wr(12'h711, 8'h00);
			u_pefb_periph.lc_pulse;
		join
		rd(12'h711, 8'h10);
		wr(12'h714, 8'h00);
		wr(12'h711, 8'h00);
		wr(12'h713, 8'h03);
		wr(12'h714, 8'h01);
		#1 `CHK(irq, 1'b0)
		$display("race test done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		t_reset;
		t_gate;
		t_ccp;
		t_race;
		summarize;
	end
	// Whole run needs about 90 cycles
	initial begin
		repeat (1000) @(posedge core_clk);
		n_mismatch++;
		summarize;
	end
endmodule
`default_nettype wire
